// *** hw/bit_matrix_product_unit.sv ***
// Bit matrix product unit: transposed matrix store, GF(2) multiply, result buffer
`timescale 1ns/1ps
`default_nettype none
//
// Function
// [RL1] Six slices of 22 operand bits; the last slice per half ties two inputs low.
// [RL2] Each slice stores 32 elements by 22 bits of the transposed matrix.
// [RL3] Slices form 32 partial results; the owning half combines them into result bits.
// [RL4] Control enters once and is relayed by two slice relay registers.
// [RL5] Loading stores the matrix transposed: element and bit position swap.
// [RL6] Result bit j is XOR over k of a(k) AND b(j,k).
// [RL7] Matrix side comes from the vector length, 1 to 64.
// [RL8] Issuer places matrices left-justified from element 0, bit 63.
// [RL9] Issuer zeroes bits beyond the matrix width.
// [RL10] Issuer supplies square matrices of equal size.
// [RL11] Vector elements outside the matrix produce no result write.
// [RL12] Vector form gives one result element per source element inside the matrix.
// [RL13] Scalar form gives one 64-bit result to a scalar destination.
// [RL14] Low load takes elements 0 to 63, high load elements 64 to 127.
// [RL15] Clear instruction drops the matrix-loaded flag.
// [RL16] Loading the last row sets the flag; it holds until clear or reset.
// [RL17] Even elements use pipe zero, odd ones pipe one, each with its own copy.
module bit_matrix_product_unit
  import bmm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Beats from issue
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire request_type req,
  // Results to the register files
  output logic             resValid,
  input  wire logic        resReady,
  output result_type       res,
  // Status
  output logic             matrixLoaded
);
  localparam int LW = $clog2(DEPTH+2);

  typedef struct packed {
    op_type           op;
    logic [IDX_W-1:0] size;
  } control_type;

  // Stage one: the operand beat and two relayed control copies
  logic             s1Valid_q, s1Valid_d;
  request_type      s1Req_q, s1Req_d;
  control_type      ctlRelay_q [2];
  control_type      ctlRelay_d [2];
  logic             reqReady_q, reqReady_d;
  logic             matrixLoaded_q, matrixLoaded_d;
  logic [MAT_MAX-1:0] tq_q [PIPE_COUNT][MAT_MAX];
  logic [MAT_MAX-1:0] tq_d [PIPE_COUNT][MAT_MAX];

  logic               accept;
  logic [IDX_W-1:0]   loadBase, loadRow;
  logic               isLoad, loadWrite, loadLast, clearHit;
  logic [MAT_MAX-1:0] bBits;
  logic [MAT_MAX-1:0] aBits [2];
  logic [MAT_MAX-1:0] sizeMask;
  logic [SLICE_ELEMS-1:0] partial [PIPE_COUNT][SLICE_COUNT];
  logic [MAT_MAX-1:0] cBits [PIPE_COUNT];
  logic               pipeSel;
  logic               fifoPush, fifoInReady;
  result_type         pushData;
  logic [LW-1:0]      fifoLevel;

  assign accept = reqValid && reqReady_q;

  // Single copy of control is captured into the two relay slices
  always_comb begin
    s1Valid_d = accept;
    s1Req_d   = accept ? req : s1Req_q;
    for (int h = 0; h < 2; h++) begin
      ctlRelay_d[h] = accept ? control_type'{req.op, matrixSize(req.vectorLength)} : ctlRelay_q[h]; // RL4 RL7
    end
    // Margin covers the beat in stage one, the one taken this cycle and the one taken with this ready
    reqReady_d = fifoLevel <= LW'(DEPTH - FIFO_MARGIN);
  end

  always_comb begin
    for (int k = 0; k < MAT_MAX; k++) begin
      sizeMask[MAT_MAX-1-k] = k < int'(ctlRelay_q[0].size); // RL7
      bBits[k]              = s1Req_q.data[MAT_MAX-1-k];
    end
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < MAT_MAX; k++) begin
        // Matrix bit zero sits in register bit 63
        aBits[h][k] = s1Req_q.data[MAT_MAX-1-k] && (k < int'(ctlRelay_q[h].size)); // RL7
      end
    end
  end

  // Load decode
  always_comb begin
    isLoad    = s1Valid_q && (ctlRelay_q[0].op == OP_LOAD_LOW || ctlRelay_q[0].op == OP_LOAD_HIGH);
    loadBase  = (ctlRelay_q[0].op == OP_LOAD_HIGH) ? HIGH_LOAD_BASE : LOW_LOAD_BASE; // RL14
    loadRow   = IDX_W'(s1Req_q.index - loadBase);
    loadWrite = isLoad && s1Req_q.index >= loadBase && loadRow < ctlRelay_q[0].size; // RL14
    loadLast  = loadWrite && loadRow == IDX_W'(ctlRelay_q[0].size - 1'b1);
    clearHit  = s1Valid_q && ctlRelay_q[0].op == OP_CLEAR;
  end

  // Storage indexed by bit position then element: one beat writes one column
  always_comb begin
    tq_d = tq_q;
    if (loadWrite) begin
      for (int p = 0; p < PIPE_COUNT; p++) begin
        for (int k = 0; k < MAT_MAX; k++) begin
          tq_d[p][k][loadRow[5:0]] = bBits[k]; // RL5 RL17
        end
      end
    end
  end

  always_comb begin
    matrixLoaded_d = matrixLoaded_q;
    if (clearHit) begin
      matrixLoaded_d = 1'b0; // RL15
    end
    // A completed load wins over a clear in the same cycle
    if (loadLast) begin
      matrixLoaded_d = 1'b1; // RL16
    end
  end

  // Slice s covers elements of half s/3 and bit group s%3
  for (genvar p = 0; p < PIPE_COUNT; p++) begin : g_pipe
    for (genvar s = 0; s < SLICE_COUNT; s++) begin : g_slice
      localparam int HALF = s / SLICE_GROUPS;
      localparam int BASE = (s % SLICE_GROUPS) * SLICE_BITS;
      localparam int REAL = (s % SLICE_GROUPS == SLICE_GROUPS-1) ? SLICE_REAL_LAST : SLICE_BITS;
      logic [SLICE_BITS-1:0]  sliceA;
      logic [SLICE_ELEMS-1:0] part;
      always_comb begin
        for (int kk = 0; kk < SLICE_BITS; kk++) begin
          sliceA[kk] = (kk < REAL) ? aBits[HALF][6'(BASE + kk)] : 1'b0; // RL1
        end
        part = '0;
        for (int e = 0; e < SLICE_ELEMS; e++) begin
          for (int kk = 0; kk < REAL; kk++) begin
            part[e] = part[e] ^ (sliceA[kk] & tq_q[p][6'(BASE + kk)][6'(HALF*SLICE_ELEMS + e)]); // RL2 RL6
          end
        end
      end
      assign partial[p][s] = part;
    end
    // Partials travel to the half that owns each result bit
    always_comb begin
      for (int j = 0; j < MAT_MAX; j++) begin
        cBits[p][j] = 1'b0;
        for (int g = 0; g < SLICE_GROUPS; g++) begin
          cBits[p][j] = cBits[p][j] ^ partial[p][(j / SLICE_ELEMS) * SLICE_GROUPS + g][j % SLICE_ELEMS]; // RL3
        end
      end
    end
  end

  // Result forming and push into the buffer
  always_comb begin
    pipeSel           = (ctlRelay_q[1].op == OP_MUL_VECTOR) && s1Req_q.index[0]; // RL17
    pushData.toScalar = ctlRelay_q[1].op == OP_MUL_SCALAR; // RL13
    pushData.index    = s1Req_q.index;
    for (int j = 0; j < MAT_MAX; j++) begin
      pushData.data[MAT_MAX-1-j] = cBits[pipeSel][j] && (j < int'(ctlRelay_q[1].size)); // RL6
    end
    fifoPush = s1Valid_q && fifoInReady &&
               ((ctlRelay_q[1].op == OP_MUL_VECTOR && s1Req_q.index < ctlRelay_q[1].size) || // RL11 RL12
                ctlRelay_q[1].op == OP_MUL_SCALAR); // RL13
  end

  result_fifo #(
    .WIDTH ($bits(result_type)),
    .DEPTH (DEPTH)
  ) u_result_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   (pushData),
    .outValid (resValid),
    .outReady (resReady),
    .outData  (res),
    .level    (fifoLevel)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      s1Valid_q      <= 1'b0;
      s1Req_q        <= '0;
      ctlRelay_q     <= '{default: '0};
      reqReady_q     <= READY_RESET;
      matrixLoaded_q <= LOADED_RESET;
      tq_q           <= '{default: '0};
    end else begin
      s1Valid_q      <= s1Valid_d;
      s1Req_q        <= s1Req_d;
      ctlRelay_q     <= ctlRelay_d;
      reqReady_q     <= reqReady_d;
      matrixLoaded_q <= matrixLoaded_d;
      tq_q           <= tq_d;
    end
  end

  assign reqReady     = reqReady_q;
  assign matrixLoaded = matrixLoaded_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Result bit zero recomputed from each pipe's own stored copy
  logic colParity [PIPE_COUNT];
  always_comb begin
    for (int p = 0; p < PIPE_COUNT; p++) begin
      colParity[p] = 1'b0;
      for (int k = 0; k < MAT_MAX; k++) begin
        colParity[p] = colParity[p] ^ (aBits[0][k] & tq_q[p][k][0]);
      end
    end
  end

  // Results owed by taken multiply beats; a lost or doubled result drives this past one
  logic [1:0] owed_q, owed_d;
  logic       owes;
  always_comb begin
    owes   = accept && (req.op == OP_MUL_SCALAR ||
                        (req.op == OP_MUL_VECTOR && req.index < matrixSize(req.vectorLength)));
    owed_d = owed_q;
    if (owes) begin
      owed_d = 2'(owed_d + 2'h1);
    end
    if (fifoPush) begin
      owed_d = 2'(owed_d - 2'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      owed_q <= 2'h0;
    end else begin
      owed_q <= owed_d;
    end
  end

  a_relay_copies_agree: assert property (s1Valid_q |-> ctlRelay_q[0] == ctlRelay_q[1]) // RL4
    else $error("relay copies of control differ");
  a_transpose_store_col: assert property (loadWrite |=> tq_q[1][0][$past(loadRow[5:0])] == $past(bBits[0])) // RL5
    else $error("loaded element not stored as a column");
  a_pipe_copies_agree: assert property (tq_q[0][0] == tq_q[1][0] // RL17
                                        && tq_q[0][MAT_MAX-1] == tq_q[1][MAT_MAX-1])
    else $error("pipe copies of the matrix differ");
  a_scalar_bit_zero: assert property (fifoPush && pushData.toScalar |-> pushData.data[63] == colParity[0]) // RL6
    else $error("scalar result bit zero wrong");
  a_size_masks_result: assert property (fifoPush |-> (pushData.data & ~sizeMask) == 64'h0000000000000000) // RL7
    else $error("result bits beyond matrix size not zero");
  a_size_clamped: assert property (s1Valid_q // RL7
                                   |-> ctlRelay_q[0].size != 7'h00 && ctlRelay_q[0].size <= FULL_SIZE)
    else $error("matrix size outside 1 to 64");
  a_outside_no_write: assert property (s1Valid_q && ctlRelay_q[1].op == OP_MUL_VECTOR // RL11
                                       && s1Req_q.index >= ctlRelay_q[1].size |-> !fifoPush)
    else $error("element outside matrix produced a result");
  a_vector_one_result: assert property (accept && req.op == OP_MUL_VECTOR // RL12
                                        && req.index < matrixSize(req.vectorLength)
                                        |=> fifoPush && pushData.index == $past(req.index))
    else $error("vector element gave no result");
  a_owed_bounded: assert property (owed_q <= 2'h1) // RL12
    else $error("multiply beat lost or doubled its result");
  a_load_no_result: assert property (s1Valid_q // RL14
                                     && ctlRelay_q[1].op inside {OP_LOAD_LOW, OP_LOAD_HIGH, OP_CLEAR}
                                     |-> !fifoPush)
    else $error("load or clear produced a result");
  a_high_load_range: assert property (s1Valid_q && ctlRelay_q[0].op == OP_LOAD_HIGH // RL14
                                      && s1Req_q.index < HIGH_LOAD_BASE |-> !loadWrite)
    else $error("high load wrote a low element");
  a_clear_drops_flag: assert property (clearHit |=> !matrixLoaded_q) // RL15
    else $error("clear did not drop loaded flag");
  a_loaded_holds: assert property (matrixLoaded_q && !clearHit |=> matrixLoaded_q) // RL16
    else $error("loaded flag fell without clear");
  a_last_row_sets: assert property (loadLast |=> matrixLoaded_q ##1 matrixLoaded_q || $past(clearHit)) // RL16
    else $error("last row load did not set flag");
  a_flag_rise_cause: assert property (!matrixLoaded_q ##1 matrixLoaded_q |-> $past(loadLast)) // RL16
    else $error("loaded flag set without a last row");
  a_even_uses_pipe0: assert property (fifoPush && !pushData.toScalar && !pushData.index[0] // RL17
                                      |-> pushData.data[63] == colParity[0])
    else $error("even element result not from pipe zero");
  a_odd_uses_pipe1: assert property (fifoPush && !pushData.toScalar && pushData.index[0] // RL17
                                     |-> pushData.data[63] == colParity[1])
    else $error("element sent to wrong pipe");
  a_buffer_never_drops: assert property (s1Valid_q |-> fifoInReady) // RL13
    else $error("result buffer full when result formed");
  a_result_holds: assert property (resValid && !resReady |=> resValid && $stable(res)) // RL12
    else $error("result changed before it was taken");


  c_load_complete: cover property (loadLast ##1 matrixLoaded_q);
  c_vector_result: cover property (fifoPush && !pushData.toScalar && pushData.index[0]);
  c_scalar_result: cover property (fifoPush && pushData.toScalar);
  c_buffer_backpressure: cover property (!reqReady_q && resValid && !resReady);
  c_clear_while_loaded: cover property (clearHit && matrixLoaded_q);

endmodule // bit_matrix_product_unit
`default_nettype wire

// *** hw/bmm_pkg.sv ***
// Shared constants, opcodes and carrier types of the bit matrix product unit
package bmm_pkg;

  localparam int MAT_MAX         = 64;   // Largest matrix side in bits
  localparam int IDX_W           = 7;    // Element index and vector length width
  localparam int SLICE_COUNT     = 6;    // Bit slices per element pipe
  localparam int SLICE_GROUPS    = 3;    // Bit groups per row half
  localparam int SLICE_BITS      = 22;   // Operand bits per slice
  localparam int SLICE_REAL_LAST = 20;   // Real bits of the last slice of each half
  localparam int SLICE_ELEMS     = 32;   // Stored elements per slice
  localparam int PIPE_COUNT      = 2;    // Even and odd element pipes
  localparam int FIFO_DEPTH      = 16;   // Result buffer words
  localparam int FIFO_MARGIN     = 3;    // Free words kept for beats in flight

  localparam logic [IDX_W-1:0] LOW_LOAD_BASE  = 7'h00;
  localparam logic [IDX_W-1:0] HIGH_LOAD_BASE = 7'h40;
  localparam logic [IDX_W-1:0] FULL_SIZE      = 7'h40;
  localparam logic             LOADED_RESET   = 1'b0;
  localparam logic             READY_RESET    = 1'b0;

  typedef enum logic [2:0] {
    OP_LOAD_LOW   = 3'b000,
    OP_LOAD_HIGH  = 3'b001,
    OP_MUL_VECTOR = 3'b010,
    OP_MUL_SCALAR = 3'b011,
    OP_CLEAR      = 3'b100
  } op_type;

  // One beat from issue: an element of the source vector or the scalar word
  typedef struct packed {
    op_type             op;
    logic [IDX_W-1:0]   vectorLength;
    logic [IDX_W-1:0]   index;
    logic [63:0]        data;
  } request_type;

  typedef struct packed {
    logic               toScalar;
    logic [IDX_W-1:0]   index;
    logic [63:0]        data;
  } result_type;

  // Zero or anything above the maximum selects the full matrix
  function automatic logic [IDX_W-1:0] matrixSize(input logic [IDX_W-1:0] vl);
    return (vl == 7'h00 || vl > FULL_SIZE) ? FULL_SIZE : vl;
  endfunction

endpackage

// *** hw/result_fifo.sv ***
// Synchronous FIFO with a registered output word
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  // Words held, output register included
  output logic [$clog2(DEPTH+2)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+2);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             outValid_q, outValid_d;
  logic [WIDTH-1:0] outData_q, outData_d;
  logic             push, pop;

  always_comb begin
    inReady    = count_q < CW'(DEPTH);
    push       = inValid && inReady;
    pop        = (!outValid_q || outReady) && count_q != '0;
    wrPtr_d    = push ? PW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d    = pop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d    = CW'(count_q + CW'(push) - CW'(pop));
    outData_d  = pop ? mem[rdPtr_q] : outData_q;
    outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
  end

  // Storage has no reset; only pointers, count and the output stage need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      count_q    <= '0;
      outValid_q <= 1'b0;
      outData_q  <= '0;
    end else begin
      wrPtr_q    <= wrPtr_d;
      rdPtr_q    <= rdPtr_d;
      count_q    <= count_d;
      outValid_q <= outValid_d;
      outData_q  <= outData_d;
    end
  end

  assign outValid = outValid_q;
  assign outData  = outData_q;
  assign level    = CW'(count_q + CW'(outValid_q));

endmodule // result_fifo
`default_nettype wire

// *** verif/issue_model.sv ***
// Issue side and register file side model facing the product unit
`timescale 1ns/1ps
`default_nettype none
module issue_model
  import bmm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Consumer pacing: 0 prompt, 1 random, 2 hold off
  input  wire logic [1:0] stall,
  // Beats to the unit
  output logic            reqValid,
  input  wire logic       reqReady,
  output request_type     req,
  // Results from the unit
  output logic            resReady
);
  request_type beats[$];

  task automatic push(input request_type b);
    beats.push_back(b);
  endtask

  function automatic int pending();
    return beats.size() + int'(reqValid);
  endfunction

  initial begin
    reqValid = 1'b0;
    req = '0;
    resReady = 1'b0;
  end

  // A beat stays put until taken; an idle bus toggles so stale data is never mistaken for a beat
  always @(posedge clk) begin
    resReady <= (stall == 2'h0) || (stall == 2'h1 && $urandom_range(1, 0) == 1);
    if (srst) begin
      beats.delete();
      reqValid <= 1'b0;
    end else if (!reqValid || reqReady) begin
      if (beats.size() != 0) begin
        req <= beats.pop_front();
        reqValid <= 1'b1;
      end else begin
        req <= ~req;
        reqValid <= 1'b0;
      end
    end
  end
endmodule // issue_model
`default_nettype wire

// *** verif/bit_matrix_product_unit_bench.sv ***
// Self-checking bench for the bit matrix product unit with a reference model
`timescale 1ns/1ps
`default_nettype none
module bit_matrix_product_unit_bench import bmm_pkg::*; ();
  logic        clk;
  logic        srst;
  logic        reqValid;
  logic        reqReady;
  logic        resValid;
  logic        resReady;
  logic        matrixLoaded;
  logic        expLoaded;
  logic [1:0]  stall;
  logic [71:0] seen;
  logic [63:0] rows[64];
  request_type req;
  result_type  res;
  result_type  got;
  result_type  expq[$];
  int          errTotal;
  int          checkCount;
  int          sizes[7] = '{1, 20, 22, 33, 0, 50, 70};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  bit_matrix_product_unit #(.DEPTH(FIFO_DEPTH)) u_bit_matrix_product_unit (
    .clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .resValid(resValid), .resReady(resReady), .res(res), .matrixLoaded(matrixLoaded));

  issue_model u_issue_model (.clk(clk), .srst(srst), .stall(stall), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .resReady(resReady));

  task automatic check(input logic [71:0] s, input logic [71:0] e, input string what);
    checkCount++;
    if (s !== e) begin
      errTotal++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, s, e);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic int sideOf(input int vl);
    return (vl == 0 || vl > 64) ? 64 : vl;
  endfunction

  function automatic logic [63:0] fit(input int s);
    return ~64'h0 << (64 - s);
  endfunction

  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction

  // Matrix bit k of a row sits in register bit 63-k
  function automatic logic [63:0] prod(input logic [63:0] a, input int s);
    logic [63:0] r;
    r = '0;
    for (int j = 0; j < s; j++) r[63-j] = ^(a & rows[j] & fit(s));
    return r;
  endfunction

  task automatic send(input op_type op, input int vl, input int idx, input logic [63:0] d);
    request_type b;
    int s;
    int r;
    s = sideOf(vl);
    b.op = op;
    b.vectorLength = 7'(vl);
    b.index = 7'(idx);
    b.data = d & fit(s);
    r = idx - (op == OP_LOAD_HIGH ? 64 : 0);
    case (op)
      OP_LOAD_LOW, OP_LOAD_HIGH: if (r >= 0 && r < s) begin
        rows[r] = b.data;
        if (r == s - 1) expLoaded = 1'b1;
      end
      OP_MUL_VECTOR: if (idx < s) expq.push_back('{1'b0, 7'(idx), prod(b.data, s)});
      OP_MUL_SCALAR: expq.push_back('{1'b1, 7'h00, prod(b.data, s)});
      default: expLoaded = 1'b0;
    endcase
    u_issue_model.push(b);
  endtask

  // Scalar results carry no element index, so it is left out of the compare
  always @(posedge clk) begin
    if (!srst && resValid === 1'b1 && resReady) begin
      if (expq.size() == 0) check(1'b1, 1'b0, "unexpected result");
      else begin
        got = expq.pop_front();
        seen = res;
        if (got.toScalar) seen[70:64] = 7'h00;
        check(seen, got, "result");
      end
    end
  end

  task automatic drain();
    int n;
    n = 0;
    while ((u_issue_model.pending() != 0 || expq.size() != 0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      check(1'b1, 1'b0, "drain timeout");
      finalReport();
    end else begin
      repeat (4) @(posedge clk);
      check(matrixLoaded, expLoaded, "loaded flag");
      check(resValid, 1'b0, "result left over");
    end
  endtask

  task automatic doReset();
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    expq.delete();
    expLoaded = 1'b0;
    foreach (rows[i]) rows[i] = 64'h0;
    repeat (3) @(posedge clk);
    check(matrixLoaded, 1'b0, "reset flag");
    check(resValid, 1'b0, "reset valid");
  endtask

  initial begin
    errTotal = 0;
    checkCount = 0;
    srst = 1'b1;
    stall = 2'h0;
    expLoaded = 1'b0;
    void'($urandom(37375));
    doReset();
    $display("test reset done");
    for (int i = 0; i < 64; i++) send(OP_LOAD_LOW, 64, i, rnd());
    drain();
    // Consumer holds off until the buffer refuses, then drains at random pace
    stall <= 2'h2;
    for (int i = 0; i < 64; i++) send(OP_MUL_VECTOR, 64, i, rnd());
    send(OP_MUL_SCALAR, 64, 0, rnd());
    repeat (60) @(posedge clk);
    check(reqReady, 1'b0, "full buffer still takes beats");
    check(resValid, 1'b1, "full buffer shows no word");
    stall <= 2'h1;
    drain();
    $display("test full matrix done");
    // One row beyond each size below 64 is offered to a load and must not be stored
    foreach (sizes[k]) begin
      send(OP_CLEAR, sizes[k], 0, 64'h0);
      for (int i = 0; i <= sideOf(sizes[k]) && i < 64; i++)
        send(k % 2 ? OP_LOAD_HIGH : OP_LOAD_LOW, sizes[k], i + (k % 2) * 64, rnd());
      // A high load offered a low element must leave the stored rows alone
      if (k % 2) send(OP_LOAD_HIGH, sizes[k], sizes[k] % 64, rnd());
      for (int i = 0; i < sideOf(sizes[k]) + 2 && i < 128; i++) send(OP_MUL_VECTOR, sizes[k], i, rnd());
      send(OP_MUL_SCALAR, sizes[k], 0, rnd());
      drain();
    end
    for (int i = 0; i < 8; i++) send(OP_MUL_VECTOR, 64, i * 9, rnd());
    drain();
    $display("test sizes done");
    send(OP_CLEAR, 64, 0, 64'h0);
    for (int i = 0; i < 63; i++) send(OP_LOAD_LOW, 64, i, rnd());
    drain();
    send(OP_LOAD_LOW, 64, 63, rnd());
    drain();
    $display("test loaded flag done");
    stall <= 2'h2;
    for (int i = 0; i < 20; i++) send(OP_MUL_VECTOR, 64, i, rnd());
    repeat (10) @(posedge clk);
    doReset();
    stall <= 2'h0;
    send(OP_MUL_SCALAR, 64, 0, rnd());
    drain();
    $display("test reset in mid-run done");
    finalReport();
  end
endmodule // bit_matrix_product_unit_bench
`default_nettype wire
